// ---- pkg/hsl_defines.svh ----
// Register offsets, field positions, reset values and timing counts for the lamp driver
`ifndef HSL_DEFINES_SVH
`define HSL_DEFINES_SVH

// Clock rate and flash half periods
`define HSL_CLK_FREQ_MHZ     125
`define HSL_HALF_2HZ_MS      250
`define HSL_HALF_2HZ_CYC     (`HSL_HALF_2HZ_MS * 1000 * `HSL_CLK_FREQ_MHZ)

// Register byte offsets
`define HSL_REG_CTRL         8'h00
`define HSL_REG_INT_STAT     8'h04
`define HSL_REG_INT_MASK     8'h08
`define HSL_REG_LAMP_STAT    8'h0C

// Control register fields
`define HSL_CTRL_P4FN_LSB    0
`define HSL_CTRL_P4FN_MSB    1

// Event bit positions in status and mask
`define HSL_EV_SHORT         0
`define HSL_EV_FAIL          1
`define HSL_EV_MEM           2
`define HSL_EV_SUPPLY        3
`define HSL_EV_W             4

// Reset values
`define HSL_CTRL_RST         2'h1
`define HSL_MASK_RST         4'h0

`endif

// ---- pkg/hsl_pkg.sv ----
// Types shared by the lamp driver and its timebase
`default_nettype none
package hsl_pkg;

  // Lamp colour: bit 1 red, bit 0 green, both lit gives orange
  typedef enum logic [1:0] {
    HSL_OFF    = 2'h0,
    HSL_GREEN  = 2'h1,
    HSL_RED    = 2'h2,
    HSL_ORANGE = 2'h3
  } hsl_colour_e;

  // Hub operating mode reported by the supervisor, one-hot
  typedef enum logic [4:0] {
    HSL_MODE_INIT  = 5'h01,
    HSL_MODE_OPER  = 5'h02,
    HSL_MODE_WAIT  = 5'h04,
    HSL_MODE_STBY  = 5'h08,
    HSL_MODE_ISOL  = 5'h10
  } hsl_opmode_e;

  // Function of the fourth port's C/Q pin
  typedef enum logic [1:0] {
    HSL_PIN_DIS = 2'h0,
    HSL_PIN_IOL = 2'h1,
    HSL_PIN_DI  = 2'h2,
    HSL_PIN_DO  = 2'h3
  } hsl_pinfn_e;

  // Whole state of the lamp driver
  typedef struct packed {
    hsl_colour_e hub_status;
    hsl_colour_e wireless_mode;
    hsl_colour_e power;
    hsl_colour_e op_mode;
    hsl_colour_e signal_input;
    hsl_colour_e valve_port;
    hsl_colour_e regulator_port;
    hsl_colour_e port3_cq;
    hsl_colour_e port3_iq;
    hsl_colour_e port4_cq;
    hsl_colour_e port4_iq;
    hsl_pinfn_e  port4_fn;
    logic [3:0]  int_stat;
    logic [3:0]  int_mask;
    logic [3:0]  ev_prev;
    logic [31:0] rdata;
    logic        irq;
  } hsl_state_s;

endpackage
`default_nettype wire

// ---- rtl/hsl_flash_timebase.sv ----
// Flash timebase: 2 Hz and 1 Hz square waves divided from the system clock
`default_nettype none
module hsl_flash_timebase
  import hsl_pkg::*;
#(
  parameter int HALF_CYC = 31250000
) (
  input  wire logic clk,
  input  wire logic rst_b,
  output logic      flash_2hz,
  output logic      flash_1hz
);

  localparam int CW = $clog2(HALF_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          ph2;
    logic          ph1;
  } hsl_tb_state_s;

  hsl_tb_state_s q;
  hsl_tb_state_s d;

  // RULE16: divided counter
  // Equal half periods; the 1 Hz phase flips on every second 2 Hz edge
  always_comb begin
    d = q;
    if (q.cnt == CW'(HALF_CYC - 1)) begin
      d.cnt = '0;
      d.ph2 = ~q.ph2;
      if (q.ph2) begin
        d.ph1 = ~q.ph1;
      end
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign flash_2hz = q.ph2;
  assign flash_1hz = q.ph1;

endmodule
`default_nettype wire

// ---- rtl/hsl_status_led_driver.sv ----
// Status lamp controller for the remote hub variant with register port and interrupt
`include "hsl_defines.svh"
`default_nettype none
// What this block does
// RULE1: The hub status lamp stays dark when all is well and whenever supply power is absent.
// RULE2: The hub status lamp flashes green on abnormal supply voltage or a short on an output or 24 V port.
// RULE3: In pairing mode the hub status and wireless-mode lamps both flash red in phase.
// RULE4: The hub status lamp is steady red on an internal component failure.
// RULE5: The power lamp is dark unpowered, flashing green on abnormal supply, steady green otherwise.
// RULE6: Mode lamp off at init, green operating, flashing green waiting, orange standby, flashing orange isolated.
// RULE7: Signal lamp dark idle, flashing green on input short, green standby, flashing orange isolation, orange both.
// RULE8: The regulator port lamp flashes green at 1 Hz with no IO-Link device attached.
// RULE9: The regulator port lamp flashes green at 2 Hz on matching, mapping or storage write error.
// RULE10: The regulator port lamp is green communicating, orange output on, red on short, dark otherwise.
// RULE11: The third port standby lamp is orange when asserted, dark when not, red on a supply short.
// RULE12: The fourth port C/Q lamp follows the pin function, red on a short and orange on an asserted level.
// RULE13: The fourth port I/Q lamp is orange while its digital input is asserted and dark otherwise.
// RULE14: An internal memory error flashes both fourth port lamps alternately red and green over every setting.
// RULE15: Settings persist and lamps return to their prior condition after supply loss and restoration.
// RULE16: Flash patterns come from clock dividers with even duty and all lamps of one rate flash in phase.
module hsl_status_led_driver
  import hsl_pkg::*;
#(
  parameter int HALF_2HZ_CYC = `HSL_HALF_2HZ_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rdata,
  output logic             irq,
  // Hub conditions
  input  wire logic        power_present,
  input  wire logic        supply_abnormal,
  input  wire logic        output_short,
  input  wire logic        pairing,
  input  wire logic        component_fail,
  input  wire logic        wireless_mode,
  input  wire hsl_opmode_e op_mode,
  input  wire logic        standby_input,
  input  wire logic        isolation_input,
  input  wire logic        input_short,
  // Port 1 conditions
  input  wire logic        p1_out_on,
  input  wire logic        p1_short,
  // Port 2 conditions
  input  wire logic        p2_no_device,
  input  wire logic        p2_dev_error,
  input  wire logic        p2_comm,
  input  wire logic        p2_out_on,
  input  wire logic        p2_short,
  // Port 3 conditions
  input  wire logic        p3_supply_short,
  // Port 4 conditions
  input  wire logic        p4_supply_short,
  input  wire logic        p4_cq_short,
  input  wire logic        p4_no_device,
  input  wire logic        p4_dev_error,
  input  wire logic        p4_comm,
  input  wire logic        p4_cq_level,
  input  wire logic        p4_iq_level,
  input  wire logic        memory_error,
  // Lamp drives
  output hsl_colour_e      hub_status_lamp,
  output hsl_colour_e      wireless_mode_lamp,
  output hsl_colour_e      power_lamp,
  output hsl_colour_e      op_mode_lamp,
  output hsl_colour_e      signal_input_lamp,
  output hsl_colour_e      valve_port_lamp,
  output hsl_colour_e      regulator_port_lamp,
  output hsl_colour_e      port3_cq_lamp,
  output hsl_colour_e      port3_iq_lamp,
  output hsl_colour_e      port4_cq_lamp,
  output hsl_colour_e      port4_iq_lamp
);

  hsl_state_s q;
  hsl_state_s d;
  logic       flash_2hz;
  logic       flash_1hz;
  logic [3:0] ev_now;
  logic [3:0] ev_rise;
  logic [3:0] stat_clr;

  // Shared flash phases
  hsl_flash_timebase #(
    .HALF_CYC (HALF_2HZ_CYC)
  ) u_timebase (
    .clk       (clk),
    .rst_b     (rst_b),
    .flash_2hz (flash_2hz),
    .flash_1hz (flash_1hz)
  );

  // Gate a colour with a flash phase when flashing
  function automatic hsl_colour_e show(input hsl_colour_e c, input logic flash, input logic phase);
    show = (flash && !phase) ? HSL_OFF : c;
  endfunction

  // Decode a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Event sources for the sticky status
  always_comb begin
    ev_now                 = '0;
    ev_now[`HSL_EV_SHORT]  = output_short | input_short | p1_short | p2_short | p3_supply_short |
                             p4_supply_short | p4_cq_short;
    ev_now[`HSL_EV_FAIL]   = component_fail;
    ev_now[`HSL_EV_MEM]    = memory_error;
    ev_now[`HSL_EV_SUPPLY] = supply_abnormal;
    ev_rise                = ev_now & ~q.ev_prev;
    stat_clr               = (wr_en && hit(addr, `HSL_REG_INT_STAT)) ? wdata[3:0] : 4'h0;
  end

  // Next state: registers, interrupts and every lamp
  always_comb begin
    d = q;

    // Register writes; settings only reset by rst_b
    // RULE15: settings retained
    if (wr_en && hit(addr, `HSL_REG_CTRL)) begin
      d.port4_fn = hsl_pinfn_e'(wdata[`HSL_CTRL_P4FN_MSB:`HSL_CTRL_P4FN_LSB]);
    end
    if (wr_en && hit(addr, `HSL_REG_INT_MASK)) begin
      d.int_mask = wdata[3:0];
    end

    // Sticky status, new events win over a clear
    d.ev_prev  = ev_now;
    d.int_stat = (q.int_stat & ~stat_clr) | ev_rise;
    d.irq      = |(d.int_stat & d.int_mask);

    // Read data valid only in the cycle after the strobe
    d.rdata = 32'h0;
    if (rd_en) begin
      if (hit(addr, `HSL_REG_CTRL)) begin
        d.rdata = {30'h0, q.port4_fn};
      end else if (hit(addr, `HSL_REG_INT_STAT)) begin
        d.rdata = {28'h0, q.int_stat};
      end else if (hit(addr, `HSL_REG_INT_MASK)) begin
        d.rdata = {28'h0, q.int_mask};
      end else if (hit(addr, `HSL_REG_LAMP_STAT)) begin
        d.rdata = {10'h0, q.hub_status, q.wireless_mode, q.power, q.op_mode, q.signal_input,
                   q.valve_port, q.regulator_port, q.port3_cq, q.port3_iq, q.port4_cq, q.port4_iq};
      end
    end

    // Hub status lamp, failure first, then pairing, then faults
    // RULE4: failure steady red
    if (component_fail) begin
      d.hub_status = HSL_RED;
    // RULE3: pairing red flash
    end else if (pairing) begin
      d.hub_status = show(HSL_RED, 1'b1, flash_1hz);
    // RULE2: fault green flash
    end else if (supply_abnormal || output_short) begin
      d.hub_status = show(HSL_GREEN, 1'b1, flash_1hz);
    // RULE1: dark when healthy
    end else begin
      d.hub_status = HSL_OFF;
    end

    // Wireless mode lamp
    // RULE3: same phase as hub
    if (pairing) begin
      d.wireless_mode = show(HSL_RED, 1'b1, flash_1hz);
    end else if (wireless_mode) begin
      d.wireless_mode = HSL_GREEN;
    end else begin
      d.wireless_mode = HSL_OFF;
    end

    // RULE5: power lamp states
    d.power = show(HSL_GREEN, supply_abnormal, flash_1hz);

    // RULE6: operating mode lamp
    unique case (op_mode)
      HSL_MODE_INIT: begin
        d.op_mode = HSL_OFF;
      end
      HSL_MODE_OPER: begin
        d.op_mode = HSL_GREEN;
      end
      HSL_MODE_WAIT: begin
        d.op_mode = show(HSL_GREEN, 1'b1, flash_1hz);
      end
      HSL_MODE_STBY: begin
        d.op_mode = HSL_ORANGE;
      end
      HSL_MODE_ISOL: begin
        d.op_mode = show(HSL_ORANGE, 1'b1, flash_1hz);
      end
      default: begin
        d.op_mode = HSL_OFF;
      end
    endcase

    // RULE7: signal input lamp
    if (input_short) begin
      d.signal_input = show(HSL_GREEN, 1'b1, flash_1hz);
    end else if (standby_input && isolation_input) begin
      d.signal_input = HSL_ORANGE;
    end else if (isolation_input) begin
      d.signal_input = show(HSL_ORANGE, 1'b1, flash_1hz);
    end else if (standby_input) begin
      d.signal_input = HSL_GREEN;
    end else begin
      d.signal_input = HSL_OFF;
    end

    // Port 1 valve output lamp
    if (p1_short) begin
      d.valve_port = HSL_RED;
    end else if (p1_out_on) begin
      d.valve_port = HSL_ORANGE;
    end else begin
      d.valve_port = HSL_OFF;
    end

    // Port 2 regulator lamp
    // RULE10: short red first
    if (p2_short) begin
      d.regulator_port = HSL_RED;
    // RULE9: errors at 2 Hz
    end else if (p2_dev_error) begin
      d.regulator_port = show(HSL_GREEN, 1'b1, flash_2hz);
    // RULE10: communicating green
    end else if (p2_comm) begin
      d.regulator_port = HSL_GREEN;
    // RULE8: no device 1 Hz
    end else if (p2_no_device) begin
      d.regulator_port = show(HSL_GREEN, 1'b1, flash_1hz);
    // RULE10: output on orange
    end else if (p2_out_on) begin
      d.regulator_port = HSL_ORANGE;
    end else begin
      d.regulator_port = HSL_OFF;
    end

    // RULE11: standby input lamp
    if (p3_supply_short) begin
      d.port3_cq = HSL_RED;
    end else if (standby_input) begin
      d.port3_cq = HSL_ORANGE;
    end else begin
      d.port3_cq = HSL_OFF;
    end
    d.port3_iq = isolation_input ? HSL_ORANGE : HSL_OFF;

    // RULE12: fourth port by function
    unique case (q.port4_fn)
      HSL_PIN_DIS: begin
        d.port4_cq = p4_supply_short ? HSL_RED : HSL_OFF;
      end
      HSL_PIN_IOL: begin
        if (p4_supply_short || p4_cq_short) begin
          d.port4_cq = HSL_RED;
        end else if (p4_dev_error) begin
          d.port4_cq = show(HSL_GREEN, 1'b1, flash_2hz);
        end else if (p4_comm) begin
          d.port4_cq = HSL_GREEN;
        end else if (p4_no_device) begin
          d.port4_cq = show(HSL_GREEN, 1'b1, flash_1hz);
        end else begin
          d.port4_cq = HSL_OFF;
        end
      end
      HSL_PIN_DI: begin
        if (p4_supply_short) begin
          d.port4_cq = HSL_RED;
        end else begin
          d.port4_cq = p4_cq_level ? HSL_ORANGE : HSL_OFF;
        end
      end
      HSL_PIN_DO: begin
        if (p4_supply_short || p4_cq_short) begin
          d.port4_cq = HSL_RED;
        end else begin
          d.port4_cq = p4_cq_level ? HSL_ORANGE : HSL_OFF;
        end
      end
    endcase

    // RULE13: I/Q mirrors level
    d.port4_iq = p4_iq_level ? HSL_ORANGE : HSL_OFF;

    // RULE14: memory error overrides
    if (memory_error) begin
      d.port4_cq = flash_1hz ? HSL_RED : HSL_GREEN;
      d.port4_iq = flash_1hz ? HSL_RED : HSL_GREEN;
    end

    // Everything dark while unpowered; lamps recompute on return
    // RULE1: dark without supply
    // RULE15: previous condition restored
    if (!power_present) begin
      d.hub_status     = HSL_OFF;
      d.wireless_mode  = HSL_OFF;
      d.power          = HSL_OFF;
      d.op_mode        = HSL_OFF;
      d.signal_input   = HSL_OFF;
      d.valve_port     = HSL_OFF;
      d.regulator_port = HSL_OFF;
      d.port3_cq       = HSL_OFF;
      d.port3_iq       = HSL_OFF;
      d.port4_cq       = HSL_OFF;
      d.port4_iq       = HSL_OFF;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q          <= '0;
      q.port4_fn <= hsl_pinfn_e'(`HSL_CTRL_RST);
      q.int_mask <= `HSL_MASK_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign rdata               = q.rdata;
  assign irq                 = q.irq;
  assign hub_status_lamp     = q.hub_status;
  assign wireless_mode_lamp  = q.wireless_mode;
  assign power_lamp          = q.power;
  assign op_mode_lamp        = q.op_mode;
  assign signal_input_lamp   = q.signal_input;
  assign valve_port_lamp     = q.valve_port;
  assign regulator_port_lamp = q.regulator_port;
  assign port3_cq_lamp       = q.port3_cq;
  assign port3_iq_lamp       = q.port3_iq;
  assign port4_cq_lamp       = q.port4_cq;
  assign port4_iq_lamp       = q.port4_iq;

endmodule
`default_nettype wire

// ---- tb/hsl_viewer.sv ----
// Operator model: watches one lamp and counts its visible changes
`default_nettype none
module hsl_viewer
  import hsl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire hsl_colour_e lamp,
  output logic [15:0]      flips
);
  timeunit 1ns;
  timeprecision 1ps;
  hsl_colour_e seen_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_q <= HSL_OFF;
      flips  <= 16'h0;
    end else begin
      seen_q <= lamp;
      if (lamp != seen_q) begin
        flips <= flips + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/hsl_status_led_driver_chk.sv ----
// Port assertions for the lamp driver, bound into it
`default_nettype none
module hsl_chk
  import hsl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        rd_en,
  input wire logic        irq,
  input wire logic        power_present,
  input wire logic        supply_abnormal,
  input wire logic        pairing,
  input wire logic        component_fail,
  input wire logic        p2_short,
  input wire logic        p3_supply_short,
  input wire logic        p4_iq_level,
  input wire logic        memory_error,
  input wire logic [31:0] rdata,
  input wire hsl_opmode_e op_mode,
  input wire hsl_colour_e hub_status_lamp,
  input wire hsl_colour_e wireless_mode_lamp,
  input wire hsl_colour_e power_lamp,
  input wire hsl_colour_e op_mode_lamp,
  input wire hsl_colour_e regulator_port_lamp,
  input wire hsl_colour_e port3_cq_lamp,
  input wire hsl_colour_e port4_cq_lamp,
  input wire hsl_colour_e port4_iq_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_dark_unpowered: assert property (
    !power_present |=> {hub_status_lamp, wireless_mode_lamp, power_lamp, op_mode_lamp, port4_cq_lamp} == 10'h0)
    else $error("lamp lit while unpowered");
  a_fail_red: assert property (
    power_present && component_fail |=> hub_status_lamp == HSL_RED)
    else $error("hub lamp not red on failure");
  a_pair_sync: assert property (
    power_present && pairing && !component_fail |=>
    hub_status_lamp == wireless_mode_lamp && hub_status_lamp inside {HSL_OFF, HSL_RED})
    else $error("pairing lamps out of step");
  a_power_green: assert property (
    power_present && !supply_abnormal |=> power_lamp == HSL_GREEN)
    else $error("power lamp not steady green");
  a_mode_green: assert property (
    power_present && op_mode == HSL_MODE_OPER |=> op_mode_lamp == HSL_GREEN)
    else $error("mode lamp not green in operation");
  a_reg_short: assert property (
    power_present && p2_short |=> regulator_port_lamp == HSL_RED)
    else $error("regulator lamp not red on short");
  a_standby_red: assert property (
    power_present && p3_supply_short |=> port3_cq_lamp == HSL_RED)
    else $error("standby lamp not red on short");
  a_iq_mirror: assert property (
    power_present && !memory_error |=> port4_iq_lamp == ($past(p4_iq_level) ? HSL_ORANGE : HSL_OFF))
    else $error("port4 input lamp wrong");
  a_mem_alt: assert property (
    power_present && memory_error |=> port4_cq_lamp == port4_iq_lamp && port4_cq_lamp inside {HSL_RED, HSL_GREEN})
    else $error("memory error pattern wrong");
  a_rdata_idle: assert property (
    !rd_en |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  c_pairing: cover property (power_present && pairing && hub_status_lamp == HSL_RED);
  c_mem: cover property (memory_error && port4_cq_lamp == HSL_GREEN);
  c_irq: cover property ($rose(irq));
endmodule
bind hsl_status_led_driver hsl_chk u_chk (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the status lamp driver
`default_nettype none
module tb_top
  import hsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam hsl_colour_e K = HSL_OFF, G = HSL_GREEN, R = HSL_RED, O = HSL_ORANGE;
  logic        clk, rst_b, wr_en, rd_en, power_present, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, seed, r2;
  logic        supply_abnormal, output_short, pairing, component_fail, wireless_mode, standby_input;
  logic        isolation_input, input_short, p1_out_on, p1_short, p2_no_device, p2_dev_error, p2_comm;
  logic        p2_out_on, p2_short, p3_supply_short, p4_supply_short, p4_cq_short, p4_no_device;
  logic        p4_dev_error, p4_comm, p4_cq_level, p4_iq_level, memory_error;
  hsl_opmode_e op_mode;
  hsl_colour_e hub_status_lamp, wireless_mode_lamp, power_lamp, op_mode_lamp, signal_input_lamp, valve_port_lamp;
  hsl_colour_e regulator_port_lamp, port3_cq_lamp, port3_iq_lamp, port4_cq_lamp, port4_iq_lamp;
  logic [1:0]  pfn;
  logic [15:0] cnt, flips, f0;
  int          num_errors, total_checks, k;
  wire logic [21:0] lamps = {hub_status_lamp, wireless_mode_lamp, power_lamp, op_mode_lamp, signal_input_lamp,
    valve_port_lamp, regulator_port_lamp, port3_cq_lamp, port3_iq_lamp, port4_cq_lamp, port4_iq_lamp};

  hsl_status_led_driver #(.HALF_2HZ_CYC(8)) DUT (.*);
  hsl_viewer u_view (.clk(clk), .rst_b(rst_b), .lamp(hub_status_lamp), .flips(flips));

  // Clock and cycle count since reset release
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk or negedge rst_b) cnt <= rst_b ? cnt + 16'h1 : 16'h0;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction
  function automatic hsl_colour_e fl(input hsl_colour_e c, input logic p);
    return p ? c : K;
  endfunction
  // Expected lamp word for 1 Hz phase a and 2 Hz phase b
  function automatic logic [21:0] ex(input logic a, input logic b);
    hsl_colour_e h, w, m, s, g, c4, i4;
    h = component_fail ? R : pairing ? fl(R, a) : (supply_abnormal | output_short) ? fl(G, a) : K;
    w = pairing ? fl(R, a) : wireless_mode ? G : K;
    case (op_mode)
      HSL_MODE_OPER: m = G;
      HSL_MODE_WAIT: m = fl(G, a);
      HSL_MODE_STBY: m = O;
      HSL_MODE_ISOL: m = fl(O, a);
      default: m = K;
    endcase
    s = input_short ? fl(G, a) : (standby_input & isolation_input) ? O : isolation_input ? fl(O, a) :
        standby_input ? G : K;
    g = p2_short ? R : p2_dev_error ? fl(G, b) : p2_comm ? G : p2_no_device ? fl(G, a) : p2_out_on ? O : K;
    case (pfn)
      2'h0: c4 = p4_supply_short ? R : K;
      2'h1: c4 = (p4_supply_short | p4_cq_short) ? R : p4_dev_error ? fl(G, b) : p4_comm ? G :
                 p4_no_device ? fl(G, a) : K;
      2'h2: c4 = p4_supply_short ? R : p4_cq_level ? O : K;
      default: c4 = (p4_supply_short | p4_cq_short) ? R : p4_cq_level ? O : K;
    endcase
    i4 = p4_iq_level ? O : K;
    if (memory_error) begin
      c4 = a ? R : G;
      i4 = c4;
    end
    if (!power_present) return 22'h0;
    return {h, w, supply_abnormal ? fl(G, a) : G, m, s, p1_short ? R : p1_out_on ? O : K, g,
            p3_supply_short ? R : standby_input ? O : K, isolation_input ? O : K, c4, i4};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic set(input logic p, input logic [23:0] c, input hsl_opmode_e m);
    power_present <= p;
    op_mode       <= m;
    {supply_abnormal, output_short, pairing, component_fail, wireless_mode, standby_input, isolation_input,
     input_short, p1_out_on, p1_short, p2_no_device, p2_dev_error, p2_comm, p2_out_on, p2_short, p3_supply_short,
     p4_supply_short, p4_cq_short, p4_no_device, p4_dev_error, p4_comm, p4_cq_level, p4_iq_level,
     memory_error} <= c;
  endtask
  // Let lamps settle, then compare away from flash edges
  task automatic look();
    repeat (2) @(posedge clk);
    #1;
    for (k = 0; k < 8 && !(cnt[2:0] inside {3'h3, 3'h4, 3'h5}); k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 8) num_errors++;
    chk(lamps, ex(cnt[4], cnt[3]));
  endtask
  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #400000;
    num_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    {rst_b, addr, wdata, wr_en, rd_en} = '0;
    set(1'b1, 24'h0, HSL_MODE_INIT);
    seed = 32'hCE6A;
    pfn = 2'h1;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h00, 32'h1);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h10, 32'hFFFFFFFF);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    wr(8'h08, 32'h1);
    @(posedge clk);
    set(1'b1, 24'h004000, HSL_MODE_INIT);
    look();
    chk(irq, 1'b1);
    rd(8'h0C, ex(1'b0, 1'b0));
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    @(posedge clk);
    set(1'b1, 24'h104000, HSL_MODE_INIT);
    look();
    chk(irq, 1'b0);
    rd(8'h04, 32'h2);
    wr(8'h08, 32'h2);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b1);
    wr(8'h04, 32'hF);
    for (int e = 2; e < 4; e++) begin
      wr(8'h08, 32'h1 << e);
      @(posedge clk);
      set(1'b1, e == 2 ? 24'h000001 : 24'h800000, HSL_MODE_OPER);
      look();
      chk(irq, 1'b1);
      rd(8'h04, 32'h1 << e);
      wr(8'h04, 32'hF);
      @(posedge clk);
      set(1'b1, 24'h0, HSL_MODE_INIT);
    end
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    wr(8'h00, 32'h2);
    pfn = 2'h2;
    @(posedge clk);
    set(1'b0, 24'h0400C6, HSL_MODE_OPER);
    look();
    rd(8'h0C, 32'h0);
    rd(8'h00, 32'h2);
    @(posedge clk);
    set(1'b1, 24'h0400C6, HSL_MODE_OPER);
    look();
    f0 = flips;
    @(posedge clk);
    set(1'b1, 24'h200000, HSL_MODE_INIT);
    repeat (40) @(posedge clk);
    #1 chk(flips - f0 > 16'h1, 1'b1);
    repeat (400) begin
      seed = lfsr(seed);
      r2 = seed;
      seed = lfsr(seed);
      if (r2[7:5] == 3'h0) begin
        wr(8'h00, seed);
        pfn = seed[1:0];
      end
      @(posedge clk);
      set(|seed[31:29], seed[23:0] & r2[31:8], hsl_opmode_e'(5'h1 << (r2[4:0] % 5)));
      look();
    end
    close_out();
  end
endmodule
`default_nettype wire
